// >>> src/cpu_call_branch_sequencer.sv
// cycle sequencer for load, store, decrement, branches, call and return
`timescale 1ns/100ps
`include "cpu_seq_map.svh"
module cpu_call_branch_sequencer #(
   parameter int          DATA_W   = 8,
   parameter int          ADDR_W   = 16,
   parameter logic [15:0] RESET_PC = `PROG_CTR_RESET
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic [15:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             mem_write_o,
   output logic             mem_read_o,
   output logic             opcode_fetch_o,
   output logic [7:0]       accumulator_o,
   output logic [15:0]      program_counter_o,
   output logic [15:0]      stack_pointer_o,
   output logic             negative_o,
   output logic             zero_o,
   output logic             unsupported_o
);

   // the datapath is written for an 8-bit data, 16-bit address machine only
   if (DATA_W != 8) begin : g_bad_data_w
      $error("sequencer supports only DATA_W=8");
   end
   if (ADDR_W != 16) begin : g_bad_addr_w
      $error("sequencer supports only ADDR_W=16");
   end

   typedef struct packed {
      cpu_seq_pkg::seq_state_t state;
      logic [15:0]             pc;
      logic [15:0]             sp;
      logic [7:0]              acc;
      logic                    neg;
      logic                    zero;
      logic [7:0]              opcode;
      logic [7:0]              hi;
      logic [7:0]              lo;
      logic [15:0]             addr;
      logic [7:0]              wdata;
      logic                    we;
      logic                    re;
      logic                    fetch;
      logic                    unsup;
   } seq_regs_t;

   seq_regs_t cur;
   seq_regs_t next_cur;

   function automatic logic [15:0] step16(input logic [15:0] v);
      step16 = v + 16'h0001;
   endfunction : step16

   function automatic logic [15:0] back16(input logic [15:0] v);
      back16 = v - 16'h0001;
   endfunction : back16

   function automatic logic [15:0] direct_ea(input logic [7:0] low);
      direct_ea = {`DIRECT_PAGE_HI, low};
   endfunction : direct_ea

   function automatic logic is_bitclr(input logic [7:0] op);
      is_bitclr = (op[7:4] == `OP_BITCLR_HI_NIB) && op[0];
   endfunction : is_bitclr

   logic        ld_neg;
   logic        ld_zero;
   logic [7:0]  flag_src;
   logic        br_taken;
   logic [15:0] br_target;

   seq_flag_unit #(
      .DATA_W (DATA_W)
   ) u_flags (
      .value_i    (flag_src),
      .negative_o (ld_neg),
      .zero_o     (ld_zero)
   );

   seq_branch_unit u_branch (
      .opcode_i   (cur.opcode),
      .offset_i   (cur.lo),
      .tested_i   (cur.hi),
      .pc_i       (cur.pc),
      .negative_i (cur.neg),
      .zero_i     (cur.zero),
      .taken_o    (br_taken),
      .target_o   (br_target)
   );

   always_comb begin
      case (cur.state)
         cpu_seq_pkg::ST_LDA_IMM:  flag_src = mem_rdata_i;
         cpu_seq_pkg::ST_DEC_EXEC: flag_src = cur.acc - 8'h01;
         default:                  flag_src = cur.acc;
      endcase
   end

   always_comb begin
      next_cur       = cur;
      next_cur.we    = 1'b0;
      next_cur.re    = 1'b0;
      next_cur.fetch = 1'b0;
      case (cur.state)
         cpu_seq_pkg::ST_FETCH: begin
            next_cur.opcode = mem_rdata_i;
            next_cur.pc     = step16(cur.pc);
            next_cur.addr   = step16(cur.pc);
            next_cur.unsup  = 1'b0;
            case (mem_rdata_i)
               `OP_LOAD_ACC_IMM: begin
                  next_cur.state = cpu_seq_pkg::ST_LDA_IMM;
                  next_cur.re    = 1'b1;
               end
               `OP_STORE_ACC_DIR: begin
                  next_cur.state = cpu_seq_pkg::ST_STA_ADDR;
                  next_cur.re    = 1'b1;
               end
               `OP_JUMP_SUB_EXT: begin
                  next_cur.state = cpu_seq_pkg::ST_JSR_HI;
                  next_cur.re    = 1'b1;
               end
               `OP_DEC_ACC: begin
                  next_cur.state = cpu_seq_pkg::ST_DEC_EXEC;
               end
               `OP_BRANCH_NE,
               `OP_BRANCH_PLUS: begin
                  next_cur.state = cpu_seq_pkg::ST_BR_OFF;
                  next_cur.re    = 1'b1;
               end
               `OP_RETURN_SUB: begin
                  next_cur.state = cpu_seq_pkg::ST_RTS_INC1;
               end
               default: begin
                  if (is_bitclr(mem_rdata_i)) begin
                     next_cur.state = cpu_seq_pkg::ST_BIT_ADDR;
                  end else begin
                     // unknown opcodes are skipped as one-byte no-ops
                     next_cur.state = cpu_seq_pkg::ST_FETCH;
                     next_cur.unsup = 1'b1;
                     next_cur.fetch = 1'b1;
                  end
                  next_cur.re = 1'b1;
               end
            endcase
         end

         // load and store: one operand bus cycle, then the result
         cpu_seq_pkg::ST_LDA_IMM: begin
            next_cur.acc   = mem_rdata_i;
            next_cur.neg   = ld_neg;
            next_cur.zero  = ld_zero;
            next_cur.pc    = step16(cur.pc);
            next_cur.state = cpu_seq_pkg::ST_FETCH;
            next_cur.addr  = step16(cur.pc);
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
         end
         cpu_seq_pkg::ST_STA_ADDR: begin
            next_cur.lo    = mem_rdata_i;
            next_cur.state = cpu_seq_pkg::ST_STA_FORM;
         end
         cpu_seq_pkg::ST_STA_FORM: begin
            // the program counter steps here, during address formation
            next_cur.pc    = step16(cur.pc);
            next_cur.addr  = direct_ea(cur.lo);
            next_cur.wdata = cur.acc;
            next_cur.we    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_STA_WRITE;
         end
         cpu_seq_pkg::ST_STA_WRITE: begin
            next_cur.neg   = ld_neg;
            next_cur.zero  = ld_zero;
            next_cur.state = cpu_seq_pkg::ST_FETCH;
            next_cur.addr  = cur.pc;
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
         end

         // call: target bytes wait in hi and lo until both pushes are done
         cpu_seq_pkg::ST_JSR_HI: begin
            next_cur.hi    = mem_rdata_i;
            next_cur.pc    = step16(cur.pc);
            next_cur.addr  = step16(cur.pc);
            next_cur.re    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_JSR_LO;
         end
         cpu_seq_pkg::ST_JSR_LO: begin
            next_cur.lo    = mem_rdata_i;
            // now past all three bytes: this is the return address
            next_cur.pc    = step16(cur.pc);
            next_cur.state = cpu_seq_pkg::ST_JSR_FORM;
         end
         cpu_seq_pkg::ST_JSR_FORM: begin
            next_cur.addr  = cur.sp;
            next_cur.wdata = cur.pc[7:0];
            next_cur.we    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_PUSH_LO;
         end
         cpu_seq_pkg::ST_PUSH_LO: begin
            next_cur.sp    = back16(cur.sp);
            next_cur.addr  = back16(cur.sp);
            next_cur.wdata = cur.pc[15:8];
            next_cur.we    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_PUSH_HI;
         end
         cpu_seq_pkg::ST_PUSH_HI: begin
            next_cur.sp    = back16(cur.sp);
            next_cur.pc    = {cur.hi, cur.lo};
            next_cur.addr  = {cur.hi, cur.lo};
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_FETCH;
         end

         // decrement: the second idle cycle only pads the length to three
         cpu_seq_pkg::ST_DEC_EXEC: begin
            next_cur.acc   = flag_src;
            next_cur.neg   = ld_neg;
            next_cur.zero  = ld_zero;
            next_cur.state = cpu_seq_pkg::ST_DEC_IDLE;
         end
         cpu_seq_pkg::ST_DEC_IDLE: begin
            next_cur.addr  = cur.pc;
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_FETCH;
         end

         // bit test parks the tested byte in hi and reuses the branch path
         cpu_seq_pkg::ST_BIT_ADDR: begin
            next_cur.pc    = step16(cur.pc);
            next_cur.addr  = direct_ea(mem_rdata_i);
            next_cur.re    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_BIT_READ;
         end
         cpu_seq_pkg::ST_BIT_READ: begin
            next_cur.hi    = mem_rdata_i;
            next_cur.addr  = cur.pc;
            next_cur.re    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_BR_OFF;
         end

         // offset lands in lo; pc then points past the whole branch
         cpu_seq_pkg::ST_BR_OFF: begin
            next_cur.lo    = mem_rdata_i;
            next_cur.pc    = step16(cur.pc);
            next_cur.state = cpu_seq_pkg::ST_BR_RESOLVE;
         end
         cpu_seq_pkg::ST_BR_RESOLVE: begin
            if (br_taken) begin
               next_cur.pc   = br_target;
               next_cur.addr = br_target;
            end else begin
               next_cur.addr = cur.pc;
            end
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_FETCH;
         end

         // return: each pointer step costs one idle cycle before its read
         cpu_seq_pkg::ST_RTS_INC1: begin
            next_cur.sp    = step16(cur.sp);
            next_cur.addr  = step16(cur.sp);
            next_cur.re    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_RTS_HI;
         end
         cpu_seq_pkg::ST_RTS_HI: begin
            next_cur.hi    = mem_rdata_i;
            next_cur.state = cpu_seq_pkg::ST_RTS_INC2;
         end
         cpu_seq_pkg::ST_RTS_INC2: begin
            next_cur.sp    = step16(cur.sp);
            next_cur.addr  = step16(cur.sp);
            next_cur.re    = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_RTS_LO;
         end
         cpu_seq_pkg::ST_RTS_LO: begin
            next_cur.lo    = mem_rdata_i;
            next_cur.state = cpu_seq_pkg::ST_RTS_LOAD;
         end
         cpu_seq_pkg::ST_RTS_LOAD: begin
            next_cur.pc    = {cur.hi, cur.lo};
            next_cur.addr  = {cur.hi, cur.lo};
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
            next_cur.state = cpu_seq_pkg::ST_FETCH;
         end

         // unreachable codes fall back to a fetch at pc rather than stall
         default: begin
            next_cur.state = cpu_seq_pkg::ST_FETCH;
            next_cur.addr  = cur.pc;
            next_cur.re    = 1'b1;
            next_cur.fetch = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cur.state  <= cpu_seq_pkg::ST_FETCH;
         cur.pc     <= RESET_PC;
         cur.sp     <= `STACK_PTR_RESET;
         cur.acc    <= `ACC_RESET;
         cur.neg    <= 1'b0;
         cur.zero   <= 1'b0;
         cur.opcode <= 8'h00;
         cur.hi     <= 8'h00;
         cur.lo     <= 8'h00;
         cur.addr   <= RESET_PC;
         cur.wdata  <= 8'h00;
         cur.we     <= 1'b0;
         cur.re     <= 1'b1;
         cur.fetch  <= 1'b1;
         cur.unsup  <= 1'b0;
      end else if (ce_i) begin
         cur <= next_cur;
      end
   end

   always_comb begin
      mem_addr_o        = cur.addr;
      mem_wdata_o       = cur.wdata;
      mem_write_o       = cur.we;
      mem_read_o        = cur.re;
      opcode_fetch_o    = cur.fetch;
      accumulator_o     = cur.acc;
      program_counter_o = cur.pc;
      stack_pointer_o   = cur.sp;
      negative_o        = cur.neg;
      zero_o            = cur.zero;
      unsupported_o     = cur.unsup;
   end

endmodule : cpu_call_branch_sequencer

// >>> src/cpu_seq_map.svh
// constants for the call and branch sequencer: opcodes, reset values, direct page high byte
//Behaviour
//- loading the accumulator copies the loaded value's top bit into negative flag.
//- branch-if-plus jumps to its relative target when negative flag is clear.
//- bit-clear branch tests a direct-page bit, branches when zero; bit 7 uses 0f.
//- a call diverts to the subroutine; return resumes after the call.
//- extended call reads opcode, high byte, low byte, then forms the target.
//- call pushes return low byte, decrements pointer, pushes high byte, decrements again.
//- saved return address is the byte just after the three-byte call.
//- decrement accumulator takes three cycles including its opcode fetch.
//- branch-if-not-equal is opcode then offset byte, in consecutive cycles.
//- taken branch adds the signed offset to the program counter past the branch.
//- branch-if-not-equal falls through when the zero flag is set.
//- return takes six cycles including its opcode fetch.
//- return increments pointer, reads high, increments, reads low, loads program counter.
//- direct store takes four cycles: opcode, address, formation, write accumulator.
//- direct effective address is zero high byte over the fetched byte.
//- immediate load fetches opcode, then reads next byte into the accumulator.
//- zero flag sets on a zero accumulator result, clears otherwise.
//- bit-test branches are three bytes: opcode, direct address, offset.
`ifndef CPU_SEQ_MAP_SVH
`define CPU_SEQ_MAP_SVH
`define OP_LOAD_ACC_IMM     8'ha6
`define OP_STORE_ACC_DIR    8'hb7
`define OP_JUMP_SUB_EXT     8'hcd
`define OP_DEC_ACC          8'h4a
`define OP_BRANCH_NE        8'h26
`define OP_BRANCH_PLUS      8'h2a
`define OP_RETURN_SUB       8'h81
`define OP_BITCLR_HI_NIB    4'h0
`define DIRECT_PAGE_HI      8'h00
`define STACK_PTR_RESET     16'h00ff
`define PROG_CTR_RESET      16'h0100
`define ACC_RESET           8'h00
`endif

// >>> src/cpu_seq_pkg.sv
// state type used by the sequencer
package cpu_seq_pkg;
   typedef enum logic [4:0] {
      ST_FETCH      = 5'h00,
      ST_LDA_IMM    = 5'h01,
      ST_STA_ADDR   = 5'h02,
      ST_STA_FORM   = 5'h03,
      ST_STA_WRITE  = 5'h04,
      ST_JSR_HI     = 5'h05,
      ST_JSR_LO     = 5'h06,
      ST_JSR_FORM   = 5'h07,
      ST_PUSH_LO    = 5'h08,
      ST_PUSH_HI    = 5'h09,
      ST_DEC_EXEC   = 5'h0a,
      ST_DEC_IDLE   = 5'h0b,
      ST_BR_OFF     = 5'h0c,
      ST_BR_RESOLVE = 5'h0d,
      ST_BIT_ADDR   = 5'h0e,
      ST_BIT_READ   = 5'h0f,
      ST_RTS_INC1   = 5'h10,
      ST_RTS_HI     = 5'h11,
      ST_RTS_INC2   = 5'h12,
      ST_RTS_LO     = 5'h13,
      ST_RTS_LOAD   = 5'h14
   } seq_state_t;
endpackage : cpu_seq_pkg

// >>> src/seq_flag_unit.sv
// negative and zero flags of an accumulator value
`timescale 1ns/100ps
module seq_flag_unit #(
   parameter int DATA_W = 8
) (
   input  wire logic [DATA_W-1:0] value_i,
   output logic                   negative_o,
   output logic                   zero_o
);
   always_comb begin
      negative_o = value_i[DATA_W-1];
      zero_o     = (value_i == '0);
   end
endmodule : seq_flag_unit

// >>> src/seq_branch_unit.sv
// branch condition and relative target
`timescale 1ns/100ps
`include "cpu_seq_map.svh"
module seq_branch_unit (
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  offset_i,
   input  wire logic [7:0]  tested_i,
   input  wire logic [15:0] pc_i,
   input  wire logic        negative_i,
   input  wire logic        zero_i,
   output logic             taken_o,
   output logic [15:0]      target_o
);
   logic [2:0] bit_sel;
   always_comb begin
      bit_sel = opcode_i[3:1];
      case (opcode_i)
         `OP_BRANCH_NE:   taken_o = ~zero_i;
         `OP_BRANCH_PLUS: taken_o = ~negative_i;
         default:         taken_o = ~tested_i[bit_sel];
      endcase
      // pc already points past the whole branch
      target_o = pc_i + {{8{offset_i[7]}}, offset_i};
   end
endmodule : seq_branch_unit

// >>> test/prog_memory_model.sv
// program and data memory facing the sequencer, zero wait state
`timescale 1ns/100ps
module prog_memory_model (
   input  wire logic        clk_sys_i,
   input  wire logic        ce_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h5a;
   // unread cycles show the inverse of the last byte so stale data never matches
   assign rdata_o = read_i ? mem[addr_i] : ~last;
   always @(posedge clk_sys_i) begin
      if (ce_i && read_i)
         last <= mem[addr_i];
      if (ce_i && write_i)
         mem[addr_i] <= wdata_i;
   end
endmodule : prog_memory_model

// >>> test/cpu_call_branch_sequencer_sva.sv
// bus order and flag checks for the call and branch sequencer
`timescale 1ns/100ps
module cpu_call_branch_sequencer_sva (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic [7:0]  mem_rdata_i,
   input wire logic [15:0] mem_addr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic        mem_write_o,
   input wire logic        mem_read_o,
   input wire logic        opcode_fetch_o,
   input wire logic [7:0]  accumulator_o,
   input wire logic [15:0] stack_pointer_o,
   input wire logic        negative_o,
   input wire logic        zero_o
);
   logic [2:0] bit_q;
   default clocking dcb @(posedge clk_sys_i); endclocking
   // a frozen cycle aborts an attempt rather than skewing its counts
   default disable iff (rst_i || !ce_i);
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && opcode_fetch_o)
         bit_q <= mem_rdata_i[3:1];
   end
   property p_branch(logic [7:0] op, logic skip);
      opcode_fetch_o && mem_rdata_i == op |=>
         mem_read_o && !opcode_fetch_o && mem_addr_o == $past(mem_addr_o) + 16'h1
         ##1 !mem_read_o ##1 opcode_fetch_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h1
         + (skip ? 16'h0 : {{8{$past(mem_rdata_i[7], 2)}}, $past(mem_rdata_i, 2)});
   endproperty
   AST_LOAD_FLAGS: assert property (opcode_fetch_o && mem_rdata_i == 8'ha6 ##1 1'b1 |=>
      opcode_fetch_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h2
      && accumulator_o == $past(mem_rdata_i) && negative_o == $past(mem_rdata_i[7])
      && zero_o == ($past(mem_rdata_i) == 8'h00)) else $error("load result or flags wrong");
   AST_STORE_SEQ: assert property (opcode_fetch_o && mem_rdata_i == 8'hb7 |=>
      mem_read_o && mem_addr_o == $past(mem_addr_o) + 16'h1 ##1 !mem_read_o && !mem_write_o
      ##1 mem_write_o && mem_addr_o == {8'h00, $past(mem_rdata_i, 2)} && mem_wdata_o == accumulator_o
      ##1 opcode_fetch_o && mem_addr_o == $past(mem_addr_o, 4) + 16'h2)
      else $error("store cycle order wrong");
   AST_DEC_LEN: assert property (opcode_fetch_o && mem_rdata_i == 8'h4a |=>
      (!mem_read_o && !opcode_fetch_o) [*2] ##1 opcode_fetch_o
      && accumulator_o == $past(accumulator_o, 3) - 8'h01 && zero_o == (accumulator_o == 8'h00)
      && negative_o == accumulator_o[7]) else $error("decrement length or result wrong");
   AST_BNE: assert property (p_branch(8'h26, zero_o))
      else $error("not-equal branch wrong");
   AST_BPL: assert property (p_branch(8'h2a, negative_o))
      else $error("plus branch wrong");
   AST_BITCLR: assert property (opcode_fetch_o && mem_rdata_i[7:4] == 4'h0 && mem_rdata_i[0] |=>
      mem_read_o && mem_addr_o == $past(mem_addr_o) + 16'h1
      ##1 mem_read_o && mem_addr_o == {8'h00, $past(mem_rdata_i)}
      ##1 mem_read_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h1 ##1 !mem_read_o
      ##1 opcode_fetch_o && mem_addr_o == $past(mem_addr_o, 2) + 16'h1
      + ((($past(mem_rdata_i, 3) >> bit_q) & 8'h01) == 8'h00
         ? {{8{$past(mem_rdata_i[7], 2)}}, $past(mem_rdata_i, 2)} : 16'h0))
      else $error("bit clear branch wrong");
   AST_CALL_SEQ: assert property (opcode_fetch_o && mem_rdata_i == 8'hcd |=>
      mem_read_o && mem_addr_o == $past(mem_addr_o) + 16'h1
      ##1 mem_read_o && mem_addr_o == $past(mem_addr_o) + 16'h1 ##1 !mem_read_o && !mem_write_o
      ##1 mem_write_o && mem_addr_o == stack_pointer_o
      && mem_wdata_o == $past(mem_addr_o[7:0], 2) + 8'h01
      ##1 mem_write_o && mem_addr_o == stack_pointer_o
      && mem_wdata_o == 8'(($past(mem_addr_o, 3) + 16'h1) >> 8)
      ##1 opcode_fetch_o && mem_addr_o == {$past(mem_rdata_i, 5), $past(mem_rdata_i, 4)}
      && stack_pointer_o == $past(stack_pointer_o, 2) - 16'h2) else $error("call sequence wrong");
   AST_RET_SEQ: assert property (opcode_fetch_o && mem_rdata_i == 8'h81 |=>
      !mem_read_o ##1 mem_read_o && mem_addr_o == $past(stack_pointer_o, 2) + 16'h1
      ##1 !mem_read_o ##1 mem_read_o && mem_addr_o == $past(stack_pointer_o, 4) + 16'h2
      ##1 !mem_read_o ##1 opcode_fetch_o && mem_addr_o == {$past(mem_rdata_i, 4), $past(mem_rdata_i, 2)}
      && stack_pointer_o == $past(stack_pointer_o, 6) + 16'h2) else $error("return sequence wrong");
   AST_WRITE_ONLY: assert property (mem_write_o |-> !mem_read_o && mem_addr_o[15:8] == 8'h00)
      else $error("write strobe in a read cycle");
   cover property (opcode_fetch_o && mem_rdata_i == 8'hcd);
   cover property (opcode_fetch_o && mem_rdata_i == 8'h81);
   cover property (opcode_fetch_o && mem_rdata_i == 8'h0f);
endmodule : cpu_call_branch_sequencer_sva

bind cpu_call_branch_sequencer cpu_call_branch_sequencer_sva cpu_call_branch_sequencer_sva_i (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .mem_rdata_i(mem_rdata_i),
   .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_write_o(mem_write_o),
   .mem_read_o(mem_read_o), .opcode_fetch_o(opcode_fetch_o), .accumulator_o(accumulator_o),
   .stack_pointer_o(stack_pointer_o), .negative_o(negative_o), .zero_o(zero_o));

// >>> test/cpu_call_branch_sequencer_test.sv
// directed call program and random branch runs of the sequencer
`timescale 1ns/100ps
module cpu_call_branch_sequencer_test;
   logic        clk_sys_i, rst_i, ce_i, mem_write_o, mem_read_o, opcode_fetch_o;
   logic        negative_o, zero_o, unsupported_o, gaps;
   logic [7:0]  mem_rdata_i, mem_wdata_o, accumulator_o, v, off, t, dd;
   logic [15:0] mem_addr_o, program_counter_o, stack_pointer_o, a, exp_pc;
   logic [31:0] seed = 32'd2881;
   logic [31:0] r;
   logic [1:0]  mode;
   logic [2:0]  n;
   logic [15:0] path [9] = '{16'h0100, 16'h0102, 16'h0200, 16'h0201, 16'h0200, 16'h0201,
                             16'h0203, 16'h0105, 16'h0107};
   int          bad_count = 0;
   int          num_checks = 0;
   int          cycles = 0;

   cpu_call_branch_sequencer cpu_call_branch_sequencer_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .mem_rdata_i(mem_rdata_i),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_write_o(mem_write_o),
      .mem_read_o(mem_read_o), .opcode_fetch_o(opcode_fetch_o), .accumulator_o(accumulator_o),
      .program_counter_o(program_counter_o), .stack_pointer_o(stack_pointer_o),
      .negative_o(negative_o), .zero_o(zero_o), .unsupported_o(unsupported_o));
   prog_memory_model prog_memory_model_i (
      .clk_sys_i(clk_sys_i), .ce_i(ce_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .write_i(mem_write_o), .read_i(mem_read_o), .rdata_o(mem_rdata_i));

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : next_rand

   function automatic logic [15:0] branch_dest(input logic [15:0] fall, input logic [7:0] ofs,
                                               input logic take);
      return take ? fall + {{8{ofs[7]}}, ofs} : fall;
   endfunction : branch_dest

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic do_reset();
      ce_i = 1'b1;
      rst_i = 1'b1;
      repeat (12) @(negedge clk_sys_i);
      rst_i = 1'b0;
   endtask : do_reset

   // stops in the fetch cycle that the next edge consumes; ce gaps stretch it
   task automatic next_fetch(output logic [15:0] addr);
      addr = 16'hffff;
      for (int k = 0; k < 60; k++) begin
         ce_i = !gaps || (next_rand() % 4 != 0);
         if (ce_i && opcode_fetch_o) begin
            addr = mem_addr_o;
            return;
         end
         @(negedge clk_sys_i);
      end
   endtask : next_fetch

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         give_verdict();
      end
   end

   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      gaps = 1'b0;
      {prog_memory_model_i.mem[16'h0100], prog_memory_model_i.mem[16'h0101]} = 16'ha602;
      {prog_memory_model_i.mem[16'h0102], prog_memory_model_i.mem[16'h0103]} = 16'hcd02;
      {prog_memory_model_i.mem[16'h0104], prog_memory_model_i.mem[16'h0105]} = 16'h00b7;
      {prog_memory_model_i.mem[16'h0106], prog_memory_model_i.mem[16'h0107]} = 16'h029d;
      {prog_memory_model_i.mem[16'h0200], prog_memory_model_i.mem[16'h0201]} = 16'h4a26;
      {prog_memory_model_i.mem[16'h0202], prog_memory_model_i.mem[16'h0203]} = 16'hfd81;
      do_reset();
      check("reset sp", 16'h00ff, stack_pointer_o);
      check("reset pc", 16'h0100, program_counter_o);
      check("reset acc", 16'h0000, {8'h00, accumulator_o});
      for (int k = 0; k < 9; k++) begin
         next_fetch(a);
         check("fetch address", path[k], a);
         @(negedge clk_sys_i);
      end
      next_fetch(a);
      check("skipped opcode", 16'h0001, {15'h0, unsupported_o});
      check("stored byte", 16'h0000, {8'h00, prog_memory_model_i.mem[16'h0002]});
      check("pushed low", 16'h0005, {8'h00, prog_memory_model_i.mem[16'h00ff]});
      check("pushed high", 16'h0001, {8'h00, prog_memory_model_i.mem[16'h00fe]});
      check("sp after return", 16'h00ff, stack_pointer_o);
      check("flags after loop", 16'h0001, {14'h0, negative_o, zero_o});
      gaps = 1'b1;
      for (int i = 0; i < 48; i++) begin
         r = next_rand();
         {n, mode, t, off, v} = r[28:0];
         dd = 8'(next_rand());
         mode = (i < 8) ? 2'd2 : (mode == 2'd3 ? 2'd0 : mode);
         n = (i < 8) ? i[2:0] : n;
         v = (i == 8) ? 8'h00 : ((i == 9) ? 8'h80 : v);
         off = (i == 10) ? 8'hfd : off;
         prog_memory_model_i.mem[16'h0100] = 8'ha6;
         prog_memory_model_i.mem[16'h0101] = v;
         prog_memory_model_i.mem[16'h0103] = off;
         if (mode == 2'd0) begin
            prog_memory_model_i.mem[16'h0102] = 8'h2a;
            exp_pc = branch_dest(16'h0104, off, !v[7]);
         end else if (mode == 2'd1) begin
            prog_memory_model_i.mem[16'h0102] = 8'h26;
            exp_pc = branch_dest(16'h0104, off, v != 8'h00);
         end else begin
            prog_memory_model_i.mem[16'h0102] = {4'h0, n, 1'b1};
            prog_memory_model_i.mem[16'h0103] = dd;
            prog_memory_model_i.mem[16'h0104] = off;
            prog_memory_model_i.mem[{8'h00, dd}] = t;
            exp_pc = branch_dest(16'h0105, off, !t[n]);
         end
         do_reset();
         repeat (2) begin
            next_fetch(a);
            @(negedge clk_sys_i);
         end
         next_fetch(a);
         check("branch target", exp_pc, a);
         check("loaded acc", {8'h00, v}, {8'h00, accumulator_o});
         check("load flags", {14'h0, v[7], v == 8'h00}, {14'h0, negative_o, zero_o});
      end
      give_verdict();
   end
endmodule : cpu_call_branch_sequencer_test
